// *** pkg/tpw_pkg.sv ***
// constants and types shared by the pwm channel files
package tpw_pkg;

  // --------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_MODE = 6'h04;
  localparam logic [5:0] OFS_XSEL0 = 6'h08;
  localparam logic [5:0] OFS_XSEL1 = 6'h0C;
  localparam logic [5:0] OFS_XSEL2 = 6'h10;
  localparam logic [5:0] OFS_DIVCTL = 6'h14;
  localparam logic [5:0] OFS_TIMER = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1C;
  localparam logic [5:0] OFS_IRQCLR = 6'h20;
  localparam logic [5:0] OFS_IRQEN = 6'h24;
  localparam logic [5:0] OFS_COUNT = 6'h28;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_TRIG_LO = 1;
  localparam int CTRL_OVF_LO = 3;
  localparam int CTRL_POL = 5;
  localparam int CTRL_IRQREQ = 6;
  localparam int DIV_PRIOR = 0;
  localparam int DIV_PCLK = 1;
  localparam int XSEL_EXT = 3;
  localparam int NUM_EVT = 2;
  localparam int EVT_FALL = 0;
  localparam int EVT_RELOAD = 1;

  // --------------------------------------------------------------------
  // reset values and counts
  // --------------------------------------------------------------------
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] XSEL_RST = 8'h00;
  localparam logic [1:0] DIVCTL_RST = 2'h0;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [NUM_EVT-1:0] IRQEN_RST = 2'h0;
  localparam logic [7:0] PWM_UNITS = 8'hFF;

  // --------------------------------------------------------------------
  // encodings
  // --------------------------------------------------------------------
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] OVF_TIMER2 = 2'h0;
  localparam logic [1:0] OVF_PREV = 2'h1;

  typedef enum logic [2:0] {
    SRC_DIV12,
    SRC_DIV8,
    SRC_DIV32,
    SRC_DIV64,
    SRC_FAST,
    SRC_SLOW,
    SRC_SUB,
    SRC_NONE
  } tpw_src_t;

  typedef enum logic [2:0] {
    ST_STOP,
    ST_ARMED,
    ST_DELAY,
    ST_HIGH,
    ST_LOW
  } tpw_state_t;

endpackage

// *** pkg/tpw_src_if.sv ***
// count source configuration and tick between channel core and source selector
`timescale 1ns/1ps
interface tpw_src_if;
  logic [1:0] modeClk;
  logic [3:0] extNibble;
  logic priorDiv;
  logic pclkSel;
  logic tick;

  modport sel (
    input modeClk,
    input extNibble,
    input priorDiv,
    input pclkSel,
    output tick
  );

  modport core (
    output modeClk,
    output extNibble,
    output priorDiv,
    output pclkSel,
    input tick
  );
endinterface

// *** verilog/tpw_src_sel.sv ***
// count source selector: divided system clocks, oscillators and subclock
`timescale 1ns/1ps
module tpw_src_sel (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic oscFastTick,
  input wire logic oscSlowTick,
  input wire logic subclockTick,
  tpw_src_if.sel src
);

  logic [5:0] divCnt_q;
  logic [4:0] subCnt_q;
  tpw_pkg::tpw_src_t srcSel;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      divCnt_q <= 6'h00;
    end else begin
      divCnt_q <= divCnt_q + 6'h01;
    end
  end

  // subclock ticks are counted, not the system clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      subCnt_q <= 5'h00;
    end else if (subclockTick) begin
      subCnt_q <= subCnt_q + 5'h01;
    end
  end

  always_comb begin
    srcSel = tpw_pkg::SRC_NONE;
    if (!src.extNibble[tpw_pkg::XSEL_EXT]) begin
      case (src.modeClk)
        2'h0: srcSel = tpw_pkg::SRC_DIV12;
        2'h1: srcSel = tpw_pkg::SRC_DIV8;
        2'h2: srcSel = tpw_pkg::SRC_DIV32;
        default: srcSel = tpw_pkg::SRC_SUB;
      endcase
    end else begin
      srcSel = tpw_pkg::tpw_src_t'(src.extNibble[2:0]);
      // prior division leaves only the divided system clocks valid
      if (src.priorDiv && src.extNibble[2]) begin
        srcSel = tpw_pkg::SRC_NONE;
      end
    end
  end

  always_comb begin
    case (srcSel)
      tpw_pkg::SRC_DIV12: src.tick = src.pclkSel ? 1'b1 : divCnt_q[0];
      tpw_pkg::SRC_DIV8: src.tick = &divCnt_q[2:0];
      tpw_pkg::SRC_DIV32: src.tick = &divCnt_q[4:0];
      tpw_pkg::SRC_DIV64: src.tick = &divCnt_q;
      tpw_pkg::SRC_FAST: src.tick = oscFastTick;
      tpw_pkg::SRC_SLOW: src.tick = oscSlowTick;
      tpw_pkg::SRC_SUB: src.tick = subclockTick && (&subCnt_q);
      default: src.tick = 1'b0;
    endcase
  end

endmodule

// *** verilog/tpw_pwm_channel.sv ***
// 8-bit pwm timer channel with avalon-mm register slave
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tpw_pwm_channel #(
  parameter int CHANNEL = 0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // count sources, one-cycle pulses
  input wire logic oscFastTick,
  input wire logic oscSlowTick,
  input wire logic subclockTick,
  // overflow pulses of second group timer 2, channel (i+4)%5 and (i+1)%5
  input wire logic ovfTimer2,
  input wire logic ovfPrev,
  input wire logic ovfNext,
  input wire logic triggerInputPin,
  output logic pwmOutputPin,
  output logic irq
);

  // --------------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------------
  logic [6:0] ctrl_q;
  logic [1:0] mode_q;
  logic [7:0] xsel_q [3];
  logic [1:0] divCtl_q;
  logic [15:0] timer_q;
  logic [tpw_pkg::NUM_EVT-1:0] status_q;
  logic [tpw_pkg::NUM_EVT-1:0] irqEn_q;
  logic irqReq_q;
  logic [31:0] readData_q;
  logic waitReq_q;
  logic trigPin_q;
  logic [7:0] preCnt_q;
  logic [7:0] unitLeft_q;
  logic pwmOut_q;
  logic irqOut_q;
  tpw_pkg::tpw_state_t state_q;

  logic wrTake;
  logic reqSeen;
  logic startFlag;
  logic trigEvent;
  logic unitEnd;
  logic phaseEnd;
  logic fallEvt;
  logic reloadEvt;
  logic [7:0] widthN;
  logic [7:0] prescM;
  logic [7:0] lowUnits;
  logic [tpw_pkg::NUM_EVT-1:0] evtVec;
  logic [tpw_pkg::NUM_EVT-1:0] clrVec;

  tpw_src_if srcIf ();

  function automatic logic isWrite(input logic [5:0] addr, input logic [5:0] ofs, input logic take);
    isWrite = take && (addr == ofs);
  endfunction

  assign wrTake = avs_write && !waitReq_q;
  assign reqSeen = (avs_read || avs_write) && waitReq_q;
  assign startFlag = ctrl_q[tpw_pkg::CTRL_START];
  assign widthN = timer_q[15:8];
  assign prescM = timer_q[7:0];
  assign lowUnits = tpw_pkg::PWM_UNITS - widthN;

  // --------------------------------------------------------------------
  // count source
  // --------------------------------------------------------------------
  assign srcIf.modeClk = mode_q;
  // each channel owns one nibble of the extended select registers
  assign srcIf.extNibble = (CHANNEL % 2 == 0) ? xsel_q[CHANNEL / 2][3:0] : xsel_q[CHANNEL / 2][7:4];
  assign srcIf.priorDiv = divCtl_q[tpw_pkg::DIV_PRIOR];
  assign srcIf.pclkSel = divCtl_q[tpw_pkg::DIV_PCLK];

  tpw_src_sel srcSel (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .oscFastTick(oscFastTick),
    .oscSlowTick(oscSlowTick),
    .subclockTick(subclockTick),
    .src(srcIf.sel)
  );

  // --------------------------------------------------------------------
  // bus slave handshake
  // --------------------------------------------------------------------
  // one wait state: the request is seen, then released the next edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      waitReq_q <= 1'b1;
    end else if (!waitReq_q) begin
      waitReq_q <= 1'b1;
    end else if (avs_read || avs_write) begin
      waitReq_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      readData_q <= 32'h0000_0000;
    end else if (reqSeen && avs_read) begin
      case (avs_address)
        tpw_pkg::OFS_CTRL: readData_q <= {25'h0, irqReq_q, ctrl_q[5:0]};
        tpw_pkg::OFS_MODE: readData_q <= {30'h0, mode_q};
        tpw_pkg::OFS_XSEL0: readData_q <= {24'h0, xsel_q[0]};
        tpw_pkg::OFS_XSEL1: readData_q <= {24'h0, xsel_q[1]};
        tpw_pkg::OFS_XSEL2: readData_q <= {28'h0, xsel_q[2][3:0]};
        tpw_pkg::OFS_DIVCTL: readData_q <= {30'h0, divCtl_q};
        tpw_pkg::OFS_TIMER: readData_q <= {16'h0, timer_q};
        tpw_pkg::OFS_STATUS: readData_q <= {30'h0, status_q};
        tpw_pkg::OFS_IRQEN: readData_q <= {30'h0, irqEn_q};
        tpw_pkg::OFS_COUNT: readData_q <= {13'h0, 3'(state_q), preCnt_q, unitLeft_q};
        default: readData_q <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= tpw_pkg::CTRL_RST;
    end else if (isWrite(avs_address, tpw_pkg::OFS_CTRL, wrTake)) begin
      ctrl_q <= {1'b0, avs_writedata[5:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_q <= tpw_pkg::MODE_RST;
      divCtl_q <= tpw_pkg::DIVCTL_RST;
      timer_q <= tpw_pkg::TIMER_RST;
      irqEn_q <= tpw_pkg::IRQEN_RST;
    end else begin
      if (isWrite(avs_address, tpw_pkg::OFS_MODE, wrTake)) begin
        mode_q <= avs_writedata[1:0];
      end
      // other timer registers are reset here too and load only on their own offsets
      if (isWrite(avs_address, tpw_pkg::OFS_DIVCTL, wrTake)) begin
        divCtl_q <= avs_writedata[1:0];
      end
      if (isWrite(avs_address, tpw_pkg::OFS_TIMER, wrTake)) begin
        timer_q <= avs_writedata[15:0];
      end
      if (isWrite(avs_address, tpw_pkg::OFS_IRQEN, wrTake)) begin
        irqEn_q <= avs_writedata[tpw_pkg::NUM_EVT-1:0];
      end
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : gXsel
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          xsel_q[g] <= tpw_pkg::XSEL_RST;
        end else if (isWrite(avs_address, tpw_pkg::OFS_XSEL0 + 6'(4 * g), wrTake)) begin
          xsel_q[g] <= avs_writedata[7:0];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // trigger detection
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trigPin_q <= 1'b1;
    end else begin
      trigPin_q <= triggerInputPin;
    end
  end

  always_comb begin
    case (ctrl_q[tpw_pkg::CTRL_TRIG_LO +: 2])
      tpw_pkg::TRIG_FALL: trigEvent = trigPin_q && !triggerInputPin;
      tpw_pkg::TRIG_RISE: trigEvent = !trigPin_q && triggerInputPin;
      default: begin
        case (ctrl_q[tpw_pkg::CTRL_OVF_LO +: 2])
          tpw_pkg::OVF_TIMER2: trigEvent = ovfTimer2;
          tpw_pkg::OVF_PREV: trigEvent = ovfPrev;
          default: trigEvent = ovfNext;
        endcase
      end
    endcase
  end

  // --------------------------------------------------------------------
  // counter and phase machine
  // --------------------------------------------------------------------
  // one unit is m+1 source ticks; phases are counted in units
  assign unitEnd = srcIf.tick && (preCnt_q == 8'h00);
  assign phaseEnd = unitEnd && (unitLeft_q == 8'h01);
  assign fallEvt = (state_q == tpw_pkg::ST_HIGH) && phaseEnd && (lowUnits != 8'h00);
  assign reloadEvt = ((state_q == tpw_pkg::ST_LOW) && phaseEnd) || ((state_q == tpw_pkg::ST_HIGH) && phaseEnd &&
    (lowUnits == 8'h00));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= tpw_pkg::ST_STOP;
      preCnt_q <= 8'h00;
      unitLeft_q <= 8'h00;
    end else if (!startFlag) begin
      state_q <= tpw_pkg::ST_STOP;
    end else begin
      case (state_q)
        tpw_pkg::ST_STOP: begin
          state_q <= tpw_pkg::ST_ARMED;
        end
        tpw_pkg::ST_ARMED: begin
          if (trigEvent && (widthN != 8'h00)) begin
            state_q <= tpw_pkg::ST_DELAY;
            preCnt_q <= prescM;
            unitLeft_q <= widthN;
          end
        end
        tpw_pkg::ST_DELAY: begin
          if (srcIf.tick) begin
            preCnt_q <= unitEnd ? prescM : preCnt_q - 8'h01;
            unitLeft_q <= unitEnd ? unitLeft_q - 8'h01 : unitLeft_q;
          end
          if (phaseEnd) begin
            state_q <= tpw_pkg::ST_HIGH;
            unitLeft_q <= widthN;
          end
        end
        tpw_pkg::ST_HIGH: begin
          if (srcIf.tick) begin
            preCnt_q <= unitEnd ? prescM : preCnt_q - 8'h01;
            unitLeft_q <= unitEnd ? unitLeft_q - 8'h01 : unitLeft_q;
          end
          if (fallEvt) begin
            state_q <= tpw_pkg::ST_LOW;
            unitLeft_q <= lowUnits;
          end else if (reloadEvt) begin
            unitLeft_q <= widthN;
          end
        end
        tpw_pkg::ST_LOW: begin
          if (srcIf.tick) begin
            preCnt_q <= unitEnd ? prescM : preCnt_q - 8'h01;
            unitLeft_q <= unitEnd ? unitLeft_q - 8'h01 : unitLeft_q;
          end
          if (reloadEvt) begin
            // a width of zero at reload parks the channel until a trigger
            state_q <= (widthN == 8'h00) ? tpw_pkg::ST_ARMED : tpw_pkg::ST_HIGH;
            unitLeft_q <= widthN;
          end
        end
        default: begin
          state_q <= tpw_pkg::ST_STOP;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // pin output
  // --------------------------------------------------------------------
  // follows the phase one clock later; stopped drives the inactive level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwmOut_q <= 1'b0;
    end else begin
      pwmOut_q <= (state_q == tpw_pkg::ST_HIGH) ^ ctrl_q[tpw_pkg::CTRL_POL];
    end
  end
  assign pwmOutputPin = pwmOut_q;

  // --------------------------------------------------------------------
  // interrupt request and status
  // --------------------------------------------------------------------
  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqReq_q <= 1'b0;
    end else if (fallEvt) begin
      irqReq_q <= 1'b1;
    end else if (isWrite(avs_address, tpw_pkg::OFS_CTRL, wrTake) && !avs_writedata[tpw_pkg::CTRL_IRQREQ]) begin
      irqReq_q <= 1'b0;
    end
  end

  assign evtVec = {reloadEvt, fallEvt};
  assign clrVec = isWrite(avs_address, tpw_pkg::OFS_IRQCLR, wrTake) ? avs_writedata[tpw_pkg::NUM_EVT-1:0] :
    {tpw_pkg::NUM_EVT{1'b0}};

  generate
    for (genvar e = 0; e < tpw_pkg::NUM_EVT; e++) begin : gEvt
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          status_q[e] <= 1'b0;
        end else if (evtVec[e]) begin
          status_q[e] <= 1'b1;
        end else if (clrVec[e]) begin
          status_q[e] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqOut_q <= 1'b0;
    end else begin
      irqOut_q <= |(status_q & irqEn_q);
    end
  end

  assign irq = irqOut_q;
  assign avs_readdata = readData_q;
  assign avs_waitrequest = waitReq_q;

endmodule

// *** dv/tpw_ext_model.sv ***
// trigger source and pwm load model for the pwm channel bench
`timescale 1ns/1ps
module tpw_ext_model (
  input wire logic sys_clk,
  input wire logic pwmOutputPin,
  output logic triggerInputPin,
  output int hiWidth,
  output int period,
  output int falls
);
  int cnt;
  int sinceRise;
  logic last;

  initial begin
    triggerInputPin = 1'b1;
    hiWidth = 0;
    period = 0;
    falls = 0;
    cnt = 0;
    sinceRise = 0;
    last = 1'b0;
  end

  // -------------------------------------------------
  // load side: widths measured in sys_clk cycles
  // -------------------------------------------------
  always @(posedge sys_clk) begin
    last <= pwmOutputPin;
    cnt <= (pwmOutputPin != last) ? 1 : cnt + 1;
    sinceRise <= (pwmOutputPin && !last) ? 1 : sinceRise + 1;
    if (!pwmOutputPin && last) begin
      hiWidth <= cnt;
      falls <= falls + 1;
    end
    if (pwmOutputPin && !last) begin
      period <= sinceRise;
    end
  end

  // low then high, so one pulse serves both edge modes
  task automatic pulse();
    @(posedge sys_clk);
    triggerInputPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    triggerInputPin <= 1'b1;
  endtask
endmodule

// *** dv/tpw_pwm_channel_props.sv ***
// concurrent checks on the pwm channel ports
`timescale 1ns/1ps
module tpw_pwm_channel_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic triggerInputPin,
  input wire logic pwmOutputPin,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic wrDone;
  logic startQ;
  logic polQ;
  logic ienQ;
  logic [7:0] widthQ;
  logic [7:0] wrAge;
  logic [7:0] sinceRise;
  assign wrDone = avs_write && !avs_waitrequest;

  // -------------------------------------------------
  // shadow of the software settings
  // -------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      startQ <= 1'b0;
      polQ <= 1'b0;
      ienQ <= 1'b0;
      widthQ <= 8'h00;
    end else if (wrDone && avs_address == tpw_pkg::OFS_CTRL) begin
      startQ <= avs_writedata[0];
      polQ <= avs_writedata[5];
    end else if (wrDone && avs_address == tpw_pkg::OFS_TIMER) begin
      widthQ <= avs_writedata[15:8];
    end else if (wrDone && avs_address == tpw_pkg::OFS_IRQEN) begin
      ienQ <= avs_writedata[0];
    end
  end
  // settle time after any write, saturating
  always_ff @(posedge sys_clk) begin
    if (sys_rst || wrDone) begin
      wrAge <= 8'h00;
    end else if (wrAge != 8'hFF) begin
      wrAge <= wrAge + 8'h01;
    end
  end
  // a restart is a fresh waveform, so forget the old rise
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (wrDone && avs_address == tpw_pkg::OFS_CTRL)) begin
      sinceRise <= 8'hFF;
    end else if ($rose(pwmOutputPin)) begin
      sinceRise <= 8'h00;
    end else if (sinceRise != 8'hFF) begin
      sinceRise <= sinceRise + 8'h01;
    end
  end

  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait cycle");
  property p_ack_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("waitrequest low longer than one cycle");
  property p_stop_idle;
    !startQ && wrAge >= 8'h03 |-> pwmOutputPin == polQ;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stopped channel drives active level");
  property p_fall_irq;
    $fell(pwmOutputPin) && !polQ && ienQ && wrAge >= 8'h04 |-> ##[0:3] irq;
  endproperty
  a_fall_irq: assert property (p_fall_irq) else $error("falling output without interrupt");
  property p_no_width;
    widthQ == 8'h00 && wrAge >= 8'h04 |-> pwmOutputPin == polQ;
  endproperty
  a_no_width: assert property (p_no_width) else $error("zero width still pulses");
  property p_period;
    $rose(pwmOutputPin) && !polQ && wrAge >= 8'h04 |-> sinceRise >= 8'hFE;
  endproperty
  a_period: assert property (p_period) else $error("pwm period shorter than 255 units");
  property p_sticky;
    irq && !avs_write && !$past(avs_write) |=> irq;
  endproperty
  a_sticky: assert property (p_sticky) else $error("interrupt dropped without software clear");
  property p_trig_delay;
    $fell(triggerInputPin) && !pwmOutputPin && !polQ |=> !pwmOutputPin [*2];
  endproperty
  a_trig_delay: assert property (p_trig_delay) else $error("output high right after trigger");

  c_rise: cover property ($rose(pwmOutputPin));
  c_irq: cover property ($rose(irq));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind tpw_pwm_channel tpw_pwm_channel_props u_props (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest),
  .triggerInputPin(triggerInputPin),
  .pwmOutputPin(pwmOutputPin),
  .irq(irq)
);

// *** dv/tb.sv ***
// self-checking bench for the pwm channel
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  nTests++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
  end \
end
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [31:0] held;
  logic waitReq;
  logic pinIn;
  logic pinOut;
  logic irq;
  logic fastTick = 1'b0;
  logic slowTick = 1'b0;
  logic subTick = 1'b0;
  logic [2:0] ovf = 3'h0;
  logic [6:0] trig [5] = '{7'h01, 7'h03, 7'h05, 7'h0D, 7'h15};
  int errors = 0;
  int nTests = 0;
  int cyc = 0;
  int f0 = 0;
  int hiWidth;
  int period;
  int falls;

  always #10 sys_clk = ~sys_clk;
  // oscillators with periods of 3, 5 and 2 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    fastTick <= (cyc % 3 == 0);
    slowTick <= (cyc % 5 == 0);
    subTick <= (cyc % 2 == 0);
  end

  tpw_pwm_channel #(.CHANNEL(0)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(address), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitReq), .oscFastTick(fastTick),
    .oscSlowTick(slowTick), .subclockTick(subTick), .ovfTimer2(ovf[0]), .ovfPrev(ovf[1]), .ovfNext(ovf[2]),
    .triggerInputPin(pinIn), .pwmOutputPin(pinOut), .irq(irq)
  );
  tpw_ext_model ext (
    .sys_clk(sys_clk), .pwmOutputPin(pinOut), .triggerInputPin(pinIn), .hiWidth(hiWidth), .period(period),
    .falls(falls)
  );

  // -------------------------------------------------
  // bus and sequence helpers
  // -------------------------------------------------
  task automatic busOp(input logic isWr, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    address <= a;
    wdata <= d;
    rd <= !isWr;
    wr <= isWr;
    // no local cap: only the watchdog may end a wait
    @(posedge sys_clk);
    while (waitReq !== 1'b0) begin
      @(posedge sys_clk);
    end
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic run(input logic [1:0] mode, input logic [7:0] xsel, input logic [1:0] div,
                     input logic [15:0] tmr, input logic [6:0] ctrl);
    busOp(1'b1, tpw_pkg::OFS_CTRL, 32'h0);
    busOp(1'b1, tpw_pkg::OFS_DIVCTL, {30'h0, div});
    busOp(1'b1, tpw_pkg::OFS_MODE, {30'h0, mode});
    busOp(1'b1, tpw_pkg::OFS_XSEL0, {24'h0, xsel});
    busOp(1'b1, tpw_pkg::OFS_TIMER, {16'h0, tmr});
    busOp(1'b1, tpw_pkg::OFS_CTRL, {25'h0, ctrl});
    repeat (2) @(posedge sys_clk);
    f0 = falls;
    if (ctrl[2]) begin
      ovf[ctrl[4:3]] <= 1'b1;
      @(posedge sys_clk);
      ovf <= 3'h0;
    end else begin
      ext.pulse();
    end
  endtask

  task automatic waitFalls(input int k);
    while (falls < f0 + k) begin
      @(posedge sys_clk);
    end
  endtask

  // one unit high with m=0, n=1, so the width is the source period
  task automatic srcCase(input logic [1:0] mode, input logic [7:0] xsel, input logic [1:0] div, input int unit);
    run(mode, xsel, div, 16'h0100, 7'h01);
    waitFalls(1);
    `CHK("hiWidth", unit, hiWidth)
  endtask

  task automatic conclude();
    if (errors == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    busOp(1'b0, tpw_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrlRst", {25'h0, tpw_pkg::CTRL_RST}, got)
    busOp(1'b0, 6'h3C, 32'h0);
    `CHK("unmapped", 32'h0, got)
    srcCase(2'h0, 8'h00, 2'h2, 1);
    srcCase(2'h0, 8'h00, 2'h0, 2);
    srcCase(2'h1, 8'hB0, 2'h2, 8);
    srcCase(2'h2, 8'h00, 2'h2, 32);
    srcCase(2'h3, 8'h00, 2'h2, 64);
    srcCase(2'h0, 8'h0B, 2'h2, 64);
    srcCase(2'h0, 8'h0C, 2'h2, 3);
    srcCase(2'h0, 8'h0D, 2'h2, 5);
    srcCase(2'h0, 8'h0E, 2'h2, 64);
    run(2'h0, 8'h0C, 2'h3, 16'h0100, 7'h01);
    repeat (60) @(posedge sys_clk);
    `CHK("priorNone", f0, falls)
    run(2'h0, 8'h00, 2'h2, 16'h0301, 7'h01);
    waitFalls(2);
    `CHK("high", 6, hiWidth)
    `CHK("period", 510, period)
    busOp(1'b0, tpw_pkg::OFS_CTRL, 32'h0);
    `CHK("req", 1'b1, got[6])
    busOp(1'b1, tpw_pkg::OFS_CTRL, 32'h1);
    busOp(1'b0, tpw_pkg::OFS_CTRL, 32'h0);
    `CHK("reqClr", 1'b0, got[6])
    busOp(1'b1, tpw_pkg::OFS_IRQCLR, 32'h3);
    busOp(1'b1, tpw_pkg::OFS_IRQEN, 32'h1);
    f0 = falls;
    waitFalls(1);
    repeat (2) @(posedge sys_clk);
    `CHK("irq", 1'b1, irq)
    busOp(1'b0, tpw_pkg::OFS_STATUS, 32'h0);
    `CHK("status", 1'b1, got[0])
    `CHK("reloadSt", 1'b1, got[1])
    busOp(1'b1, tpw_pkg::OFS_IRQCLR, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK("irqClr", 1'b0, irq)
    busOp(1'b1, tpw_pkg::OFS_CTRL, 32'h0);
    busOp(1'b0, tpw_pkg::OFS_COUNT, 32'h0);
    held = got;
    repeat (20) @(posedge sys_clk);
    busOp(1'b0, tpw_pkg::OFS_COUNT, 32'h0);
    `CHK("hold", held, got)
    `CHK("stopPin", 1'b0, pinOut)
    busOp(1'b1, tpw_pkg::OFS_CTRL, 32'h20);
    repeat (2) @(posedge sys_clk);
    `CHK("polPin", 1'b1, pinOut)
    run(2'h0, 8'h00, 2'h2, 16'h0000, 7'h01);
    repeat (600) @(posedge sys_clk);
    `CHK("noPulse", f0, falls)
    `CHK("noIrq", 1'b0, irq)
    foreach (trig[i]) begin
      run(2'h0, 8'h00, 2'h2, 16'h0100, trig[i]);
      waitFalls(1);
      `CHK("trig", 1'b1, falls > f0)
    end
    conclude();
  end
endmodule
